// ### rtl/aufc_frame_codec.sv
`timescale 1ns/1ps
module aufc_frame_codec (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [1:0] host_framing_select_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic [7:0] rx_frame_type_id_out,
  output logic [7:0] rx_frame_payload_out,
  output logic rx_payload_valid_out,
  output logic rx_frame_good_out,
  output logic rx_frame_bad_out,
  output logic rx_frame_known_out,
  output logic rx_frame_id_zero_out,
  output logic rx_apply_changes_out,
  input wire logic tx_start_in,
  input wire logic [15:0] tx_len_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_data_ready_out,
  output logic tx_busy_out,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in
);
  typedef struct packed {
    aufc_pkg::aufc_rx_st_t rst;
    logic resc;
    logic [15:0] rlen;
    logic [15:0] ridx;
    logic [7:0] rsum;
    logic [7:0] rtype;
    logic [7:0] rpay;
    logic rpv;
    logic rgood;
    logic rbad;
    logic rknown;
    logic rid0;
    logic rapply;
    logic err_pend;
    logic [7:0] err_code;
    aufc_pkg::aufc_tx_st_t tst;
    logic tint;
    logic [15:0] tlen;
    logic [15:0] tidx;
    logic [7:0] tsum;
    logic [7:0] tcur;
    logic tesc;
    logic [7:0] tbyte;
    logic tvalid;
  } aufc_state_t;

  aufc_state_t q;
  aufc_state_t next_q;
  logic stuff;
  logic [7:0] rb;
  logic [7:0] src;
  logic src_take;

  function automatic logic needs_esc(input logic [7:0] b);
    needs_esc = (b == aufc_pkg::DELIM) || (b == aufc_pkg::ESC) ||
      (b == aufc_pkg::XON) || (b == aufc_pkg::XOFF);
  endfunction

  function automatic logic host_type(input logic [7:0] t);
    host_type = (t == aufc_pkg::FT_LOCAL_CMD) ||
      (t == aufc_pkg::FT_QUEUED_CMD) || (t == aufc_pkg::FT_TX_REQ) ||
      (t == aufc_pkg::FT_EXPLICIT_TX) || (t == aufc_pkg::FT_REMOTE_CMD) ||
      (t == aufc_pkg::FT_CREATE_ROUTE);
  endfunction

  assign stuff = (host_framing_select_in == aufc_pkg::MODE_STUFF);

  // ==========================================================
  // combined next-state
  always_comb begin
    next_q = q;
    next_q.rpv = 1'b0;
    next_q.rgood = 1'b0;
    next_q.rbad = 1'b0;
    next_q.rapply = 1'b0;
    rb = rx_byte_in;
    src = tx_data_in;
    src_take = 1'b0;
    // ---------------- receive ----------------
    if (rx_valid_in) begin
      if (rx_byte_in == aufc_pkg::DELIM) begin
        // a delimiter always restarts parsing, dropping any partial frame
        next_q.rst = aufc_pkg::AUFC_R_LEN_HI;
        next_q.resc = 1'b0;
      end else if (q.rst == aufc_pkg::AUFC_R_HUNT) begin
        next_q.rst = aufc_pkg::AUFC_R_HUNT;
      end else if (stuff && !q.resc && rx_byte_in == aufc_pkg::ESC) begin
        next_q.resc = 1'b1;
      end else begin
        if (q.resc) begin
          rb = rx_byte_in ^ aufc_pkg::ESC_XOR;
        end
        next_q.resc = 1'b0;
        case (q.rst)
          aufc_pkg::AUFC_R_LEN_HI: begin
            next_q.rlen = {rb, aufc_pkg::ZERO8};
            next_q.rst = aufc_pkg::AUFC_R_LEN_LO;
          end
          aufc_pkg::AUFC_R_LEN_LO: begin
            next_q.rlen = {q.rlen[15:8], rb};
            next_q.ridx = aufc_pkg::LEN_ZERO;
            next_q.rsum = aufc_pkg::ZERO8;
            if ({q.rlen[15:8], rb} == aufc_pkg::LEN_ZERO ||
                {q.rlen[15:8], rb} > aufc_pkg::LEN_MAX) begin
              next_q.rst = aufc_pkg::AUFC_R_HUNT;
              next_q.rbad = 1'b1;
              next_q.err_pend = 1'b1;
              next_q.err_code = aufc_pkg::ERR_FORMAT;
            end else begin
              next_q.rst = aufc_pkg::AUFC_R_DATA;
            end
          end
          aufc_pkg::AUFC_R_DATA: begin
            next_q.rsum = q.rsum + rb;
            if (q.ridx == aufc_pkg::IDX_TYPE) begin
              next_q.rtype = rb;
              next_q.rknown = host_type(rb);
              next_q.rid0 = 1'b1;
            end else begin
              if (q.ridx == aufc_pkg::IDX_FRAME_ID) begin
                next_q.rid0 = (rb == aufc_pkg::FRAME_ID_NONE);
              end
              next_q.rpay = rb;
              next_q.rpv = 1'b1;
            end
            next_q.ridx = q.ridx + aufc_pkg::LEN_ONE;
            if (q.ridx + aufc_pkg::LEN_ONE == q.rlen) begin
              next_q.rst = aufc_pkg::AUFC_R_CHK;
            end
          end
          aufc_pkg::AUFC_R_CHK: begin
            next_q.rst = aufc_pkg::AUFC_R_HUNT;
            if (q.rsum + rb == aufc_pkg::CHK_GOOD) begin
              next_q.rgood = 1'b1;
              // a local command applies any queued parameter writes
              next_q.rapply = (q.rtype == aufc_pkg::FT_LOCAL_CMD);
            end else begin
              next_q.rbad = 1'b1;
              next_q.err_pend = 1'b1;
              next_q.err_code = aufc_pkg::ERR_CHECKSUM;
            end
          end
          default: next_q.rst = aufc_pkg::AUFC_R_HUNT;
        endcase
      end
    end
    // ---------------- transmit ----------------
    if (q.tvalid && tx_ready_in) begin
      next_q.tvalid = 1'b0;
    end
    if (!q.tvalid || tx_ready_in) begin
      case (q.tst)
        aufc_pkg::AUFC_T_IDLE: begin
          // error report waits for a quiet transmitter, never preempts
          if (q.err_pend) begin
            next_q.tint = 1'b1;
            next_q.tlen = aufc_pkg::ERR_LEN;
            next_q.tst = aufc_pkg::AUFC_T_DELIM;
          end else if (tx_start_in) begin
            next_q.tint = 1'b0;
            next_q.tlen = tx_len_in;
            next_q.tst = aufc_pkg::AUFC_T_DELIM;
          end
        end
        aufc_pkg::AUFC_T_DELIM: begin
          next_q.tbyte = aufc_pkg::DELIM;
          next_q.tvalid = 1'b1;
          next_q.tsum = aufc_pkg::ZERO8;
          next_q.tidx = aufc_pkg::LEN_ZERO;
          next_q.tesc = 1'b0;
          next_q.tst = aufc_pkg::AUFC_T_LEN_HI;
          if (q.tint) begin
            // a rejection landing in this same cycle must not be lost
            next_q.err_pend = next_q.rbad;
          end
        end
        default: begin
          // stuffed emission shared by length, data and checksum
          if (q.tesc) begin
            next_q.tbyte = q.tcur ^ aufc_pkg::ESC_XOR;
            next_q.tvalid = 1'b1;
            next_q.tesc = 1'b0;
            src_take = 1'b1;
            src = q.tcur;
          end else begin
            case (q.tst)
              aufc_pkg::AUFC_T_LEN_HI: src = q.tlen[15:8];
              aufc_pkg::AUFC_T_LEN_LO: src = q.tlen[7:0];
              aufc_pkg::AUFC_T_DATA: begin
                if (q.tint) begin
                  src = (q.tidx == aufc_pkg::IDX_TYPE) ?
                    aufc_pkg::FT_STATUS : q.err_code;
                end else begin
                  src = tx_data_in;
                end
              end
              default: src = aufc_pkg::CHK_GOOD - q.tsum;
            endcase
            if (q.tst == aufc_pkg::AUFC_T_DATA && !q.tint && !tx_start_in) begin
              src_take = 1'b0;
            end else if (stuff && needs_esc(src)) begin
              next_q.tbyte = aufc_pkg::ESC;
              next_q.tvalid = 1'b1;
              next_q.tesc = 1'b1;
              next_q.tcur = src;
            end else begin
              next_q.tbyte = src;
              next_q.tvalid = 1'b1;
              src_take = 1'b1;
            end
          end
          if (src_take) begin
            case (q.tst)
              aufc_pkg::AUFC_T_LEN_HI: next_q.tst = aufc_pkg::AUFC_T_LEN_LO;
              aufc_pkg::AUFC_T_LEN_LO: begin
                next_q.tst = (q.tlen == aufc_pkg::LEN_ZERO) ?
                  aufc_pkg::AUFC_T_CHK : aufc_pkg::AUFC_T_DATA;
              end
              aufc_pkg::AUFC_T_DATA: begin
                next_q.tsum = q.tsum + src;
                next_q.tidx = q.tidx + aufc_pkg::LEN_ONE;
                if (q.tidx + aufc_pkg::LEN_ONE == q.tlen) begin
                  next_q.tst = aufc_pkg::AUFC_T_CHK;
                end
              end
              default: next_q.tst = aufc_pkg::AUFC_T_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // outputs
  assign rx_frame_type_id_out = q.rtype;
  assign rx_frame_payload_out = q.rpay;
  assign rx_payload_valid_out = q.rpv;
  assign rx_frame_good_out = q.rgood;
  assign rx_frame_bad_out = q.rbad;
  assign rx_frame_known_out = q.rknown;
  assign rx_frame_id_zero_out = q.rid0;
  assign rx_apply_changes_out = q.rapply;
  assign tx_byte_out = q.tbyte;
  assign tx_valid_out = q.tvalid;
  assign tx_busy_out = (q.tst != aufc_pkg::AUFC_T_IDLE) || q.err_pend;
  // an escaped data byte is consumed when its second half is sent
  assign tx_data_ready_out = (q.tst == aufc_pkg::AUFC_T_DATA) && !q.tint &&
    tx_start_in && (!q.tvalid || tx_ready_in) &&
    (q.tesc || !(stuff && needs_esc(tx_data_in)));

  // ==========================================================
  // checks
  delim_restart_a: assert property (@(posedge clk_sys_in)
    disable iff (!arst_n_in)
    rx_valid_in && rx_byte_in == aufc_pkg::DELIM |=>
      q.rst == aufc_pkg::AUFC_R_LEN_HI)
    else $error("delimiter did not restart parsing");
  bad_reports_a: assert property (@(posedge clk_sys_in)
    disable iff (!arst_n_in)
    rx_frame_bad_out |-> q.err_pend)
    else $error("bad frame without status report");
  bad_hunts_a: assert property (@(posedge clk_sys_in)
    disable iff (!arst_n_in)
    rx_frame_bad_out |-> q.rst != aufc_pkg::AUFC_R_DATA)
    else $error("bad frame left parser in data");
  no_raw_special_a: assert property (@(posedge clk_sys_in)
    disable iff (!arst_n_in)
    stuff && tx_valid_out && q.tst != aufc_pkg::AUFC_T_LEN_HI &&
      !$past(q.tst == aufc_pkg::AUFC_T_DELIM) |-> tx_byte_out !=
      aufc_pkg::DELIM)
    else $error("raw delimiter inside stuffed frame");
  esc_follow_a: assert property (@(posedge clk_sys_in)
    disable iff (!arst_n_in)
    tx_valid_out && tx_ready_in && q.tesc |=>
      tx_valid_out && tx_byte_out == (q.tcur ^ aufc_pkg::ESC_XOR))
    else $error("escape not followed by xored byte");
  good_sum_a: assert property (@(posedge clk_sys_in)
    disable iff (!arst_n_in)
    rx_frame_good_out |-> !rx_frame_bad_out &&
      $past(q.rst == aufc_pkg::AUFC_R_CHK))
    else $error("frame both good and bad");
endmodule

// ### inc/aufc_pkg.sv
package aufc_pkg;
  localparam logic [1:0] MODE_PLAIN = 2'h1;
  localparam logic [1:0] MODE_STUFF = 2'h2;
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] ESC = 8'h7d;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] XON = 8'h11;
  localparam logic [7:0] XOFF = 8'h13;
  localparam logic [7:0] CHK_GOOD = 8'hff;
  // host-to-device frame types
  localparam logic [7:0] FT_LOCAL_CMD = 8'h08;
  localparam logic [7:0] FT_QUEUED_CMD = 8'h09;
  localparam logic [7:0] FT_TX_REQ = 8'h10;
  localparam logic [7:0] FT_EXPLICIT_TX = 8'h11;
  localparam logic [7:0] FT_REMOTE_CMD = 8'h17;
  localparam logic [7:0] FT_CREATE_ROUTE = 8'h21;
  // device-to-host frame types
  localparam logic [7:0] FT_CMD_RESP = 8'h88;
  localparam logic [7:0] FT_STATUS = 8'h8a;
  localparam logic [7:0] FT_TX_STATUS = 8'h8b;
  localparam logic [7:0] FT_RX = 8'h90;
  localparam logic [7:0] FT_RX_EXPLICIT = 8'h91;
  localparam logic [7:0] FT_IO_SAMPLE = 8'h92;
  localparam logic [7:0] FT_SENSOR = 8'h94;
  localparam logic [7:0] FT_NODE_ID = 8'h95;
  localparam logic [7:0] FT_REMOTE_RESP = 8'h97;
  localparam logic [7:0] FT_FW_STATUS = 8'ha0;
  localparam logic [7:0] FT_ROUTE_REC = 8'ha1;
  localparam logic [7:0] FT_MTO_REQ = 8'ha3;
  // status codes carried in status frames on receive failure
  localparam logic [7:0] ERR_CHECKSUM = 8'h01;
  localparam logic [7:0] ERR_FORMAT = 8'h02;
  localparam logic [15:0] ERR_LEN = 16'h0002;
  localparam logic [15:0] LEN_ONE = 16'h0001;
  localparam logic [15:0] LEN_ZERO = 16'h0000;
  localparam logic [15:0] LEN_MAX = 16'h0100;
  localparam logic [15:0] IDX_TYPE = 16'h0000;
  localparam logic [15:0] IDX_FRAME_ID = 16'h0001;
  localparam logic [7:0] FRAME_ID_NONE = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  typedef enum logic [2:0] {
    AUFC_R_HUNT, AUFC_R_LEN_HI, AUFC_R_LEN_LO, AUFC_R_DATA, AUFC_R_CHK
  } aufc_rx_st_t;
  typedef enum logic [2:0] {
    AUFC_T_IDLE, AUFC_T_DELIM, AUFC_T_LEN_HI, AUFC_T_LEN_LO, AUFC_T_DATA,
    AUFC_T_CHK
  } aufc_tx_st_t;
endpackage

// ### verification/aufc_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host side: frame sender and byte sink
module aufc_host_model (
  input wire logic clk_sys_in,
  input wire logic slow_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out
);
  logic [7:0] got[$];

  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  // slow host stalls every other cycle
  always @(posedge clk_sys_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_byte_in);
    end
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
  end

  task automatic put(input logic [7:0] b);
    @(posedge clk_sys_in);
    rx_byte_out <= b;
    rx_valid_out <= 1'b1;
  endtask

  // released line shows the inverse, never a stale byte
  task automatic idle();
    @(posedge clk_sys_in);
    rx_valid_out <= 1'b0;
    rx_byte_out <= ~rx_byte_out;
  endtask

  task automatic put_data(input logic [7:0] b, input logic stuff);
    if (stuff && (b == aufc_pkg::DELIM || b == aufc_pkg::ESC ||
        b == aufc_pkg::XON || b == aufc_pkg::XOFF)) begin
      put(aufc_pkg::ESC);
      put(b ^ aufc_pkg::ESC_XOR);
    end else begin
      put(b);
    end
  endtask

  task automatic send_frame(input logic [7:0] d[$], input logic stuff,
                            input logic [7:0] corrupt);
    logic [7:0] sum;
    logic [15:0] len;
    sum = 8'h00;
    len = 16'(d.size());
    put(aufc_pkg::DELIM);
    put_data(len[15:8], stuff);
    put_data(len[7:0], stuff);
    foreach (d[i]) begin
      sum = sum + d[i];
      put_data(d[i], stuff);
    end
    put_data((8'hff - sum) ^ corrupt, stuff);
    idle();
  endtask
endmodule

// ### verification/api_uart_frame_codec_bench.sv
`timescale 1ns/1ps
module api_uart_frame_codec_bench;
  logic clk_sys_in, arst_n_in, slow, rx_valid, pv, good, bad, known;
  logic idz, apply, tx_start, tx_dr, busy, tx_valid, tx_ready;
  logic [1:0] mode;
  logic [7:0] rx_byte, type_id, payload, tx_data, tx_byte, last_pl;
  logic [15:0] tx_len;
  int num_errors, checks_done, cyc, n_good, n_bad, n_apply, g0, b0, a0;

  aufc_frame_codec dut (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .host_framing_select_in(mode), .rx_byte_in(rx_byte),
    .rx_valid_in(rx_valid), .rx_frame_type_id_out(type_id),
    .rx_frame_payload_out(payload), .rx_payload_valid_out(pv),
    .rx_frame_good_out(good), .rx_frame_bad_out(bad),
    .rx_frame_known_out(known), .rx_frame_id_zero_out(idz),
    .rx_apply_changes_out(apply), .tx_start_in(tx_start),
    .tx_len_in(tx_len), .tx_data_in(tx_data),
    .tx_data_ready_out(tx_dr), .tx_busy_out(busy),
    .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
    .tx_ready_in(tx_ready)
  );
  aufc_host_model host (
    .clk_sys_in(clk_sys_in), .slow_in(slow), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .tx_byte_in(tx_byte),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  // ==========================================
  // pulse monitor and hang guard
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (good === 1'b1) n_good <= n_good + 1;
    if (bad === 1'b1) n_bad <= n_bad + 1;
    if (apply === 1'b1) n_apply <= n_apply + 1;
    if (pv === 1'b1) last_pl <= payload;
    if (cyc == 40000) begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic mark();
    g0 = n_good;
    b0 = n_bad;
    a0 = n_apply;
  endtask

  task automatic counts(input int g, b, a);
    check("good pulses", 16'(n_good - g0), 16'(g));
    check("bad pulses", 16'(n_bad - b0), 16'(b));
    check("apply pulses", 16'(n_apply - a0), 16'(a));
  endtask

  task automatic frame(input logic [7:0] d[$], input logic [1:0] m,
                       input logic [7:0] err);
    @(posedge clk_sys_in);
    mode <= m;
    host.send_frame(d, m == aufc_pkg::MODE_STUFF, err);
    repeat (4) @(posedge clk_sys_in);
  endtask

  task automatic expect_tx(input logic [7:0] e[$]);
    int k;
    k = 0;
    while (host.got.size() < e.size() && k < 3000) begin
      @(posedge clk_sys_in);
      k++;
    end
    check("tx count", 16'(host.got.size()), 16'(e.size()));
    foreach (e[i]) check("tx byte", host.got[i], e[i]);
    check("busy after", busy, 1'b0);
    host.got.delete();
  endtask

  // reset in mid-frame must drop the partial frame and quiet the outputs
  task automatic mid_reset();
    mark();
    host.put(aufc_pkg::DELIM);
    host.put(8'h00);
    host.idle();
    arst_n_in <= 1'b0;
    @(posedge clk_sys_in);
    check("valid in reset", tx_valid, 1'b0);
    check("busy in reset", busy, 1'b0);
    arst_n_in <= 1'b1;
    host.put(8'h02);
    host.put(8'h23);
    host.put(8'h11);
    host.put(8'hcb);
    host.idle();
    repeat (4) @(posedge clk_sys_in);
    counts(0, 0, 0);
    frame('{8'h23, 8'h11}, aufc_pkg::MODE_PLAIN, 8'h00);
    counts(1, 0, 0);
  endtask

  // data changes only after the edge that took it
  task automatic tx_frame(input logic [7:0] d[$]);
    int k;
    @(posedge clk_sys_in);
    tx_start <= 1'b1;
    tx_len <= 16'(d.size());
    tx_data <= d[0];
    foreach (d[i]) begin
      k = 0;
      @(negedge clk_sys_in);
      while (tx_dr !== 1'b1 && k < 2000) begin
        @(negedge clk_sys_in);
        k++;
      end
      check("busy", busy, 1'b1);
      @(posedge clk_sys_in);
      if (i + 1 < d.size()) tx_data <= d[i + 1];
      else tx_start <= 1'b0;
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    {arst_n_in, slow, tx_start, num_errors, checks_done} = '0;
    {cyc, n_good, n_bad, n_apply} = '0;
    {tx_len, tx_data, last_pl} = '0;
    mode = aufc_pkg::MODE_PLAIN;
    repeat (3) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    mark();
    host.put(8'h23);
    host.put(8'h11);
    host.put(8'hcb);
    frame('{8'h23, 8'h11}, aufc_pkg::MODE_PLAIN, 8'h00);
    counts(1, 0, 0);
    check("type", type_id, 8'h23);
    check("payload", last_pl, 8'h11);
    check("known", known, 1'b0);
    mark();
    frame('{8'h23, 8'h11}, aufc_pkg::MODE_STUFF, 8'h00);
    counts(1, 0, 0);
    check("payload", last_pl, 8'h11);
    frame('{8'h08, 8'h01, 8'h7e, 8'h7d}, aufc_pkg::MODE_STUFF, 8'h00);
    counts(2, 0, 1);
    check("payload", last_pl, 8'h7d);
    check("known", known, 1'b1);
    check("id zero", idz, 1'b0);
    mark();
    frame('{8'h09, 8'h00, 8'h42, 8'h44, 8'h07}, aufc_pkg::MODE_PLAIN,
          8'h00);
    counts(1, 0, 0);
    check("id zero", idz, 1'b1);
    slow <= 1'b1;
    mark();
    frame('{8'h08, 8'h01, 8'h4e, 8'h44}, aufc_pkg::MODE_PLAIN, 8'h01);
    counts(0, 1, 0);
    expect_tx('{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h01, 8'h74});
    frame('{8'h08, 8'h01, 8'h4e, 8'h44}, aufc_pkg::MODE_PLAIN, 8'h00);
    counts(1, 1, 1);
    check("payload", last_pl, 8'h44);
    mark();
    host.put(8'h7e);
    host.put(8'h00);
    host.put(8'h00);
    host.idle();
    repeat (4) @(posedge clk_sys_in);
    counts(0, 1, 0);
    expect_tx('{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h02, 8'h73});
    mode <= aufc_pkg::MODE_STUFF;
    tx_frame('{8'h8a, 8'h11});
    expect_tx('{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h7d, 8'h31, 8'h64});
    mode <= aufc_pkg::MODE_PLAIN;
    slow <= 1'b0;
    tx_frame('{8'h88, 8'h7e, 8'h13});
    expect_tx('{8'h7e, 8'h00, 8'h03, 8'h88, 8'h7e, 8'h13, 8'he6});
    mid_reset();
    wrap_up();
  end
endmodule
